//--- verilog/cgsb_top.v
// How it works
// - a write to generator n's control register sets busy bit 2+n of the busy register one cycle after the write answer, as its sync begins.
// - a generator's busy bit clears when its sync completes, when its clock switch finishes, or when a software reset request lands.
// - writing one to the software reset bit sets busy bit 0 as its sync begins.
// - busy bit 0 drops once the software reset request has crossed domains.
// - generator 0's control register resets to 0x106, the other eight to zero.
// - nine generator control registers sit at 0x20 plus 4 times the generator index.
//
// Register access over AXI4-Lite was left to the implementer.
`timescale 1ns/10ps
`include "cgsb_regs.vh"
module cgsb_top (
  input wire aclk, // bus clock
  input wire aresetn, // synchronous reset, active low
  input wire [7:0] s_axi_awaddr, // write address
  input wire s_axi_awvalid, // write address valid
  output reg s_axi_awready, // write address ready
  input wire [31:0] s_axi_wdata, // write data
  input wire [3:0] s_axi_wstrb, // byte enables
  input wire s_axi_wvalid, // write data valid
  output reg s_axi_wready, // write data ready
  output reg [1:0] s_axi_bresp, // write response
  output reg s_axi_bvalid, // write response valid
  input wire s_axi_bready, // write response ready
  input wire [7:0] s_axi_araddr, // read address
  input wire s_axi_arvalid, // read address valid
  output reg s_axi_arready, // read address ready
  output reg [31:0] s_axi_rdata, // read data
  output reg [1:0] s_axi_rresp, // read response
  output reg s_axi_rvalid, // read data valid
  input wire s_axi_rready, // read data ready
  input wire [8:0] gen_switch_done, // per-generator clock switch finished, pulse
  output reg [287:0] gen_applied, // control values as seen by the generator domains
  output reg soft_reset_pulse // one-cycle pulse when the reset request lands
);
  reg [31:0] gen_ctrl [0:8];
  reg [7:0] aw_addr;
  reg aw_have;
  reg [31:0] w_data;
  reg [3:0] w_strb;
  reg w_have;
  reg software_reset_request_req;
  reg [8:0] gen_start;
  reg software_reset_request_start;
  reg [7:0] div_count;
  reg tick;
  wire [8:0] gen_busy;
  wire [8:0] gen_done;
  wire software_reset_request_busy;
  wire software_reset_request_done;
  wire [31:0] busy_word;
  integer i;

  // true when the address falls on one of the generator control words
  function gen_hit;
    input [7:0] a;
    begin
      gen_hit = (a >= `CGSB_OFS_GEN) && (a <= `CGSB_GEN_LAST) && (a[1:0] == 2'h0);
    end
  endfunction

  // generator index from its byte address
  function [3:0] gen_sel;
    input [7:0] a;
    reg [7:0] d;
    begin
      d = a - `CGSB_OFS_GEN;
      gen_sel = d[5:2];
    end
  endfunction

  // apply byte enables to a stored word
  function [31:0] merge;
    input [31:0] old;
    input [31:0] nw;
    input [3:0] strb;
    integer b;
    begin
      merge = old;
      for (b = 0; b < 4; b = b + 1) begin
        if (strb[b]) begin
          merge[b*8 +: 8] = nw[b*8 +: 8];
        end
      end
    end
  endfunction

  // slow-domain enable from a divider
  always @(posedge aclk) begin
    if (!aresetn) begin
      div_count <= 8'h00;
      tick <= 1'b0;
    end else if (div_count == `CGSB_DIV - 8'h01) begin
      div_count <= 8'h00;
      tick <= 1'b1;
    end else begin
      div_count <= div_count + 8'h01;
      tick <= 1'b0;
    end
  end

  // one tracker per generator plus one for software reset
  genvar g;
  generate
    for (g = 0; g < 9; g = g + 1) begin : gen_trk
      cgsb_sync u_sync (
        .aclk(aclk),
        .aresetn(aresetn),
        .tick(tick),
        .start(gen_start[g]),
        .abort(gen_switch_done[g] | software_reset_request_done),
        .busy(gen_busy[g]),
        .done(gen_done[g])
      );
    end
  endgenerate

  cgsb_sync u_software_reset_request (
    .aclk(aclk),
    .aresetn(aresetn),
    .tick(tick),
    .start(software_reset_request_start),
    .abort(1'b0),
    .busy(software_reset_request_busy),
    .done(software_reset_request_done)
  );

  // busy register layout
  assign busy_word = {21'h000000, gen_busy, 1'b0, software_reset_request_busy};

  // write channel and register updates
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_awready <= 1'b1;
      s_axi_wready <= 1'b1;
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `CGSB_RESP_OKAY;
      aw_have <= 1'b0;
      w_have <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h00000000;
      w_strb <= 4'h0;
      software_reset_request_req <= 1'b0;
      gen_start <= 9'h000;
      software_reset_request_start <= 1'b0;
      soft_reset_pulse <= 1'b0;
      gen_ctrl[0] <= `CGSB_GEN0_RST;
      for (i = 1; i < 9; i = i + 1) begin
        gen_ctrl[i] <= `CGSB_GENN_RST;
      end
    end else begin
      gen_start <= 9'h000;
      software_reset_request_start <= 1'b0;
      soft_reset_pulse <= software_reset_request_done;
      // reset request landed: registers back to reset values; a write committed in the same cycle comes after and wins
      if (software_reset_request_done) begin
        software_reset_request_req <= 1'b0;
        gen_ctrl[0] <= `CGSB_GEN0_RST;
        for (i = 1; i < 9; i = i + 1) begin
          gen_ctrl[i] <= `CGSB_GENN_RST;
        end
      end
      if (s_axi_awvalid && s_axi_awready) begin
        aw_addr <= s_axi_awaddr;
        aw_have <= 1'b1;
        s_axi_awready <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
        w_have <= 1'b1;
        s_axi_wready <= 1'b0;
      end
      if (aw_have && w_have && !s_axi_bvalid) begin
        aw_have <= 1'b0;
        w_have <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp <= `CGSB_RESP_OKAY;
        if (gen_hit(aw_addr)) begin
          gen_ctrl[gen_sel(aw_addr)] <= merge(gen_ctrl[gen_sel(aw_addr)], w_data, w_strb);
          gen_start[gen_sel(aw_addr)] <= 1'b1;
        end else if (aw_addr == `CGSB_OFS_CTRL) begin
          if (w_strb[0] && w_data[`CGSB_CTRL_SOFTWARE_RESET_REQUEST_BIT]) begin
            software_reset_request_req <= 1'b1;
            software_reset_request_start <= 1'b1;
          end
        end else if (aw_addr != `CGSB_OFS_BUSY) begin
          s_axi_bresp <= `CGSB_RESP_SLVERR;
        end
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready <= 1'b1;
      end
    end
  end

  // generator-side copies take the value when its crossing completes
  always @(posedge aclk) begin
    if (!aresetn) begin
      gen_applied <= {256'h0, `CGSB_GEN0_RST};
    end else if (software_reset_request_done) begin
      gen_applied <= {256'h0, `CGSB_GEN0_RST};
    end else begin
      for (i = 0; i < 9; i = i + 1) begin
        if (gen_done[i]) begin
          gen_applied[i*32 +: 32] <= gen_ctrl[i];
        end
      end
    end
  end

  // read channel
  always @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h00000000;
      s_axi_rresp <= `CGSB_RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid <= 1'b1;
      s_axi_rresp <= `CGSB_RESP_OKAY;
      if (gen_hit(s_axi_araddr)) begin
        s_axi_rdata <= gen_ctrl[gen_sel(s_axi_araddr)];
      end else if (s_axi_araddr == `CGSB_OFS_BUSY) begin
        s_axi_rdata <= busy_word;
      end else if (s_axi_araddr == `CGSB_OFS_CTRL) begin
        s_axi_rdata <= {31'h00000000, software_reset_request_req};
      end else begin
        s_axi_rdata <= 32'h00000000;
        s_axi_rresp <= `CGSB_RESP_SLVERR;
      end
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end
endmodule // cgsb_top

//--- verilog/cgsb_regs.vh
`ifndef CGSB_REGS_VH
`define CGSB_REGS_VH
// register offsets (byte addresses)
`define CGSB_OFS_CTRL 8'h00
`define CGSB_OFS_BUSY 8'h04
`define CGSB_OFS_GEN 8'h20
`define CGSB_GEN_STRIDE 8'h04
`define CGSB_GEN_LAST 8'h40
// field positions
`define CGSB_CTRL_SOFTWARE_RESET_REQUEST_BIT 0
`define CGSB_BUSY_SOFTWARE_RESET_REQUEST_BIT 0
`define CGSB_BUSY_GEN_LSB 2
// reset values
`define CGSB_GEN0_RST 32'h00000106
`define CGSB_GENN_RST 32'h00000000
`define CGSB_BUSY_RST 32'h00000000
// timing counts: generator-domain tick every DIV bus clocks, sync takes SYNC_TICKS ticks
`define CGSB_DIV 8'h04
`define CGSB_SYNC_TICKS 3'h2
// bus answers
`define CGSB_RESP_OKAY 2'h0
`define CGSB_RESP_SLVERR 2'h2
`endif

//--- verilog/cgsb_sync.v
`timescale 1ns/10ps
`include "cgsb_regs.vh"
// one synchronisation tracker: busy from start until the slow domain has seen the value
module cgsb_sync (
  input wire aclk, // bus clock
  input wire aresetn, // synchronous reset, active low
  input wire tick, // slow-domain enable pulse
  input wire start, // write begins crossing
  input wire abort, // clock switch finished or software reset landed, ends the crossing early
  output reg busy, // crossing under way
  output reg done // one-cycle pulse when the crossing completes
);
  reg [2:0] count;

  // a start in the same cycle as completion keeps busy set
  always @(posedge aclk) begin
    if (!aresetn) begin
      busy <= 1'b0;
      done <= 1'b0;
      count <= 3'h0;
    end else begin
      done <= 1'b0;
      if (start) begin
        busy <= 1'b1;
        count <= 3'h0;
      end else if (busy && abort) begin
        busy <= 1'b0;
      end else if (busy && tick) begin
        if (count == `CGSB_SYNC_TICKS - 3'h1) begin
          busy <= 1'b0;
          done <= 1'b1;
        end else begin
          count <= count + 3'h1;
        end
      end
    end
  end
endmodule // cgsb_sync

//--- tb/cgsb_top_checker.sv
`timescale 1ns/10ps
module cgsb_top_checker (
  input wire aclk, // bus clock
  input wire aresetn, // reset, low
  input wire s_axi_awvalid, // aw valid
  input wire s_axi_awready, // aw ready
  input wire s_axi_wvalid, // w valid
  input wire s_axi_wready, // w ready
  input wire s_axi_bvalid, // b valid
  input wire s_axi_bready, // b ready
  input wire s_axi_arvalid, // ar valid
  input wire s_axi_arready, // ar ready
  input wire s_axi_rvalid, // r valid
  input wire [287:0] gen_applied, // applied words
  input wire soft_reset_pulse // reset landed
);
  localparam [287:0] RST_APPLIED = 288'h106;
  reg [3:0] since_b;
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  // cycles since the last write answer, saturating
  always @(posedge aclk) begin
    if (!aresetn || $rose(s_axi_bvalid)) begin
      since_b <= 4'h0;
    end else if (since_b != 4'hf) begin
      since_b <= since_b + 4'h1;
    end
  end
  // bus steps
  sequence wr_take;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence b_take;
    s_axi_bvalid && s_axi_bready;
  endsequence
  wr_answer_a: assert property (wr_take |-> ##2 s_axi_bvalid)
    else $error("write answer late");
  wr_block_a: assert property (wr_take |=> !s_axi_awready && !s_axi_wready)
    else $error("write not blocked");
  wr_release_a: assert property (b_take |=> s_axi_awready && !s_axi_bvalid)
    else $error("write not released");
  rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
    else $error("read answer late");
  reset_val_a: assert property ($rose(aresetn) |-> gen_applied == RST_APPLIED)
    else $error("bad reset words");
  pulse_len_a: assert property (soft_reset_pulse |=> !soft_reset_pulse)
    else $error("reset pulse too long");
  software_reset_request_load_a: assert property (soft_reset_pulse |-> ##[0:1] gen_applied == RST_APPLIED)
    else $error("words not reset");
  apply_delay_a: assert property ($changed(gen_applied) |-> since_b >= 4'h2 && since_b <= 4'he)
    else $error("apply out of window");
endmodule // cgsb_top_checker

//--- tb/cgsb_top_test.sv
`timescale 1ns/10ps
`define CHK(a, b) begin checks_done++; if ((a) !== (b)) begin error_cnt++; \
  $display("Error at %0t: %h vs %h", $time, a, b); end end
module cgsb_top_test;
  reg aclk = 1'b0;
  reg aresetn = 1'b0;
  reg [7:0] s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  reg [31:0] s_axi_wdata = 32'h0;
  reg [3:0] s_axi_wstrb = 4'hf;
  reg s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0, s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
  reg [8:0] gen_switch_done = 9'h000;
  wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, soft_reset_pulse;
  wire [1:0] s_axi_bresp, s_axi_rresp;
  wire [31:0] s_axi_rdata;
  wire [287:0] gen_applied;
  integer error_cnt = 0, checks_done = 0, seed = 60, n, k, j;
  reg [31:0] d, x;
  reg [1:0] r;
  reg [31:0] vals [0:8];
  cgsb_top cgsb_top_i (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
    .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .gen_switch_done, .gen_applied, .soft_reset_pulse);
  // expectations
  function [7:0] ga(input integer i);
    ga = 8'h20 + {i[5:0], 2'b00};
  endfunction
  function [31:0] bsy(input integer i);
    bsy = 32'h4 << i;
  endfunction
  function [31:0] rstv(input integer i);
    rstv = (i == 0) ? 32'h106 : 32'h0;
  endfunction
  task summarize;
    begin
      $display("errors %0d checks %0d", error_cnt, checks_done);
      if (error_cnt == 0 && checks_done > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
    end
  endtask
  task tmo(input t);
    if (t) begin
      error_cnt++;
      summarize;
    end
  endtask
  // one write, both channels offered together
  task wr(input [7:0] a, input [31:0] v);
    begin
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= v;
      s_axi_awvalid <= 1'b1;
      s_axi_wvalid <= 1'b1;
      s_axi_bready <= 1'b1;
      for (k = 0; k < 60; k++) begin
        @(posedge aclk);
        if (s_axi_awready) s_axi_awvalid <= 1'b0;
        if (s_axi_wready) s_axi_wvalid <= 1'b0;
        if (s_axi_bvalid) break;
      end
      r = s_axi_bresp;
      s_axi_bready <= 1'b0;
      tmo(k == 60);
    end
  endtask
  // one read into d and r
  task rd(input [7:0] a);
    begin
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1'b1;
      s_axi_rready <= 1'b1;
      for (k = 0; k < 60; k++) begin
        @(posedge aclk);
        if (s_axi_arready) s_axi_arvalid <= 1'b0;
        if (s_axi_rvalid) break;
      end
      d = s_axi_rdata;
      r = s_axi_rresp;
      s_axi_rready <= 1'b0;
      tmo(k == 60);
    end
  endtask
  // poll busy until clear before touching the same register
  task idle;
    begin
      for (j = 0; j < 20; j++) begin
        rd(8'h04);
        if (d === 32'h0) break;
      end
      tmo(j == 20);
    end
  endtask
  task chk_rst;
    for (n = 0; n < 9; n++) begin
      rd(ga(n));
      `CHK(d, rstv(n))
    end
  endtask
  // clock
  initial begin
    forever #4 aclk = ~aclk;
  end
  // main sequence
  initial begin
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    chk_rst;
    rd(8'h04);
    `CHK(d, 32'h0)
    for (n = 0; n < 9; n++) begin
      x = $random(seed);
      vals[n] = x;
      wr(ga(n), x);
      `CHK(r, 2'h0)
      rd(8'h04);
      `CHK(d & bsy(n), bsy(n))
      idle;
      rd(ga(n));
      `CHK(d, x)
      `CHK(gen_applied[n*32 +: 32], x)
    end
    // corner cases: half-word strobe, write to the read-only busy word
    x = $random(seed);
    s_axi_wstrb <= 4'h3;
    wr(ga(2), x);
    s_axi_wstrb <= 4'hf;
    idle;
    rd(ga(2));
    `CHK(d, {vals[2][31:16], x[15:0]})
    `CHK(gen_applied[95:64], {vals[2][31:16], x[15:0]})
    wr(8'h04, 32'hffffffff);
    `CHK(r, 2'h0)
    rd(8'h04);
    `CHK(d, 32'h0)
    x = $random(seed);
    wr(ga(4), x);
    gen_switch_done <= 9'h010;
    @(posedge aclk);
    gen_switch_done <= 9'h000;
    rd(8'h04);
    `CHK(d & bsy(4), 32'h0)
    repeat (10) @(posedge aclk);
    `CHK(gen_applied[159:128], vals[4])
    for (n = 0; n < 2; n++) begin
      rd(n ? 8'h44 : 8'h10);
      `CHK(r, 2'h2)
    end
    wr(8'h00, 32'h1);
    rd(8'h00);
    `CHK(d, 32'h1)
    rd(8'h04);
    `CHK(d[0], 1'b1)
    idle;
    rd(8'h00);
    `CHK(d, 32'h0)
    `CHK(gen_applied, {256'h0, 32'h106})
    chk_rst;
    summarize;
  end
endmodule // cgsb_top_test
bind cgsb_top cgsb_top_checker cgsb_top_checker_i (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready,
  .s_axi_wvalid, .s_axi_wready, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
  .s_axi_rvalid, .gen_applied, .soft_reset_pulse);
